// ---- logic/adc_regs_pkg.sv ----
// package: register map, field layout, reset values and encodings of the converter registers
`default_nettype none
package adc_regs_pkg;

  // apb geometry: printed offsets are register indices, byte address is four times the index
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;

  // register indices
  localparam logic [IDX_W-1:0] IDX_RESULT_LOW = 10'h078;
  localparam logic [IDX_W-1:0] IDX_RESULT_HIGH = 10'h079;
  localparam logic [IDX_W-1:0] IDX_CONTROL_A = 10'h07a;
  localparam logic [IDX_W-1:0] IDX_CONTROL_B = 10'h07b;
  localparam logic [IDX_W-1:0] IDX_MUX_SELECT = 10'h07c;
  localparam logic [IDX_W-1:0] IDX_INPUT_DISABLE = 10'h07e;

  // field widths
  localparam int RESULT_W = 10;
  localparam int CHANNEL_W = 4;
  localparam int SOURCE_W = 3;
  localparam int PIN_W = 6;
  localparam int FLAG_W = 8;

  // field positions
  localparam int CTRL_A_ENABLE_BIT = 7;
  localparam int CTRL_A_START_BIT = 6;
  localparam int CTRL_A_AUTO_BIT = 5;
  localparam int MUX_LEFT_ADJUST_BIT = 5;
  localparam int MUX_CHANNEL_LSB = 0;
  localparam int CTRL_B_SOURCE_LSB = 0;
  localparam int DISABLE_LSB = 0;

  // reset values
  localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;
  localparam logic [CHANNEL_W-1:0] CHANNEL_RESET = 4'h0;
  localparam logic [SOURCE_W-1:0] SOURCE_RESET = 3'h0;
  localparam logic [PIN_W-1:0] DISABLE_RESET = 6'h00;
  localparam logic [PIN_W-1:0] PIN_RESET = 6'h00;
  localparam logic [DATA_W-1:0] PRDATA_RESET = 32'h0000_0000;

  // auto trigger sources, index into the flag vector
  typedef enum logic [SOURCE_W-1:0] {
    SRC_FREE_RUNNING = 3'h0,
    SRC_ANALOG_COMPARATOR = 3'h1,
    SRC_EXT_INTERRUPT_0 = 3'h2,
    SRC_TIMER0_COMPARE_A = 3'h3,
    SRC_TIMER0_OVERFLOW = 3'h4,
    SRC_TIMER1_COMPARE_B = 3'h5,
    SRC_TIMER1_OVERFLOW = 3'h6,
    SRC_TIMER1_CAPTURE = 3'h7
  } trigger_source_t;

  // result pair lock after a low byte read
  typedef enum logic [1:0] {
    PAIR_OPEN = 2'b01,
    PAIR_FROZEN = 2'b10
  } freeze_state_t;

endpackage
`default_nettype wire

// ---- logic/trigger_if.sv ----
// interface: trigger flags, source selection and edge pulse between control and edge unit
`timescale 1ns/1ps
`default_nettype none
interface trigger_if;
  import adc_regs_pkg::*;
  logic [FLAG_W-1:0] flags;
  logic [SOURCE_W-1:0] source;
  logic edge_pulse;
  modport unit (input flags, input source, output edge_pulse);
  modport ctrl (output flags, output source, input edge_pulse);
endinterface
`default_nettype wire

// ---- logic/trigger_edge_unit.sv ----
// module: rising edge detector on the selected trigger flag
`timescale 1ns/1ps
`default_nettype none
module trigger_edge_unit
  import adc_regs_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  trigger_if.unit tif
);

  logic level;
  logic prev_level_reg;
  logic prev_level_next;
  logic [SOURCE_W-1:0] prev_source_reg;
  logic [SOURCE_W-1:0] prev_source_next;
  logic to_free_running;

  // selected flag; a switch of source compares against the old source's level
  assign level = tif.flags[tif.source];
  assign to_free_running = (tif.source == SRC_FREE_RUNNING) && (prev_source_reg != tif.source);
  assign tif.edge_pulse = level && !prev_level_reg && !to_free_running;

  // next state: remember level and source of this cycle
  always_comb begin
    prev_level_next = level;
    prev_source_next = tif.source;
  end

  // registers, frozen while the clock enable is low
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prev_level_reg <= 1'b0;
      prev_source_reg <= SOURCE_RESET;
    end else if (ce) begin
      prev_level_reg <= prev_level_next;
      prev_source_reg <= prev_source_next;
    end
  end

endmodule // trigger_edge_unit
`default_nettype wire

// ---- logic/adc_trigger_result_regs.sv ----
// module: converter result registers, auto trigger selection and pin input disable over apb
//
// What this block does
// - a finished conversion loads the result pair unless the pair is frozen or a low byte read is in flight
// - low byte read freezes pair until high read
// - left adjust: high bits 9:2, low 1:0 on top
// - left adjust resets cleared, right adjusted default
// - source select acts only with auto trigger
// - rising edge of selected flag triggers conversion
// - switching from a cleared to a set source is an edge
// - switching to free running never triggers
// - fixed encoding of the eight trigger sources
// - disable bits switch off pin input buffers
// - disabled pins read zero in pin register
// - channels 7 and 6 have no disable bits
`timescale 1ns/1ps
`default_nettype none
module adc_trigger_result_regs
  import adc_regs_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic conv_done,
  input wire logic [RESULT_W-1:0] conversion_result,
  input wire logic [FLAG_W-1:0] trigger_flags,
  input wire logic [PIN_W-1:0] pin_raw,
  output logic [PIN_W-1:0] pin_value,
  output logic [PIN_W-1:0] buffer_disable,
  output logic start_conversion,
  output logic converter_enable,
  output logic [CHANNEL_W-1:0] channel_select_bits
);


  // apb decode

  logic [IDX_W-1:0] idx;
  logic setup_phase;
  logic access_phase;
  logic wr_take;
  logic rd_take;
  logic hit_low;
  logic hit_high;
  logic hit_ctrl_a;
  logic hit_ctrl_b;
  logic hit_mux;
  logic hit_disable;
  logic mapped;
  logic byte0_we;

  // byte lanes above the first are ignored: every register is eight bits wide
  assign idx = paddr[ADDR_W-1:2];
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign hit_low = (idx == IDX_RESULT_LOW);
  assign hit_high = (idx == IDX_RESULT_HIGH);
  assign hit_ctrl_a = (idx == IDX_CONTROL_A);
  assign hit_ctrl_b = (idx == IDX_CONTROL_B);
  assign hit_mux = (idx == IDX_MUX_SELECT);
  assign hit_disable = (idx == IDX_INPUT_DISABLE);
  assign mapped = hit_low || hit_high || hit_ctrl_a || hit_ctrl_b || hit_mux || hit_disable;

  // zero wait state slave; unmapped addresses answer with an error in the access phase
  assign pready = 1'b1;
  assign pslverr = access_phase && !mapped;
  assign wr_take = access_phase && pwrite && mapped && ce;
  assign rd_take = access_phase && !pwrite && mapped && ce;
  assign byte0_we = wr_take && pstrb[0];


  // control registers

  logic enable_reg;
  logic enable_next;
  logic auto_reg;
  logic auto_next;
  logic left_adjust_reg;
  logic left_adjust_next;
  logic [CHANNEL_W-1:0] channel_reg;
  logic [CHANNEL_W-1:0] channel_next;
  logic [SOURCE_W-1:0] source_reg;
  logic [SOURCE_W-1:0] source_next;
  logic [PIN_W-1:0] disable_reg;
  logic [PIN_W-1:0] disable_next;
  logic sw_start;

  // next values of the software fields; reserved bits are never stored so they read zero
  always_comb begin
    enable_next = enable_reg;
    auto_next = auto_reg;
    left_adjust_next = left_adjust_reg;
    channel_next = channel_reg;
    source_next = source_reg;
    disable_next = disable_reg;
    sw_start = 1'b0;
    if (byte0_we && hit_ctrl_a) begin
      enable_next = pwdata[CTRL_A_ENABLE_BIT];
      auto_next = pwdata[CTRL_A_AUTO_BIT];
      sw_start = pwdata[CTRL_A_START_BIT];
    end
    if (byte0_we && hit_mux) begin
      left_adjust_next = pwdata[MUX_LEFT_ADJUST_BIT];
      channel_next = pwdata[MUX_CHANNEL_LSB +: CHANNEL_W];
    end
    if (byte0_we && hit_ctrl_b) begin
      source_next = pwdata[CTRL_B_SOURCE_LSB +: SOURCE_W];
    end
    if (byte0_we && hit_disable) begin
      disable_next = pwdata[DISABLE_LSB +: PIN_W];
    end
  end

  // control registers; left adjust clears at reset so results start right adjusted
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      enable_reg <= 1'b0;
      auto_reg <= 1'b0;
      left_adjust_reg <= 1'b0;
      channel_reg <= CHANNEL_RESET;
      source_reg <= SOURCE_RESET;
      disable_reg <= DISABLE_RESET;
    end else if (ce) begin
      enable_reg <= enable_next;
      auto_reg <= auto_next;
      left_adjust_reg <= left_adjust_next;
      channel_reg <= channel_next;
      source_reg <= source_next;
      disable_reg <= disable_next;
    end
  end

  assign converter_enable = enable_reg;
  assign channel_select_bits = channel_reg;
  assign buffer_disable = disable_reg;


  // auto trigger

  trigger_if tif ();
  logic start_reg;
  logic start_next;

  assign tif.flags = trigger_flags;
  assign tif.source = source_reg;

  trigger_edge_unit u_edge (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .tif(tif)
  );

  // the edge unit runs even with auto trigger off, so enabling it does not fire on a stale edge
  always_comb begin
    start_next = 1'b0;
    if (enable_reg && auto_reg && tif.edge_pulse) begin
      start_next = 1'b1;
    end
    if (enable_next && sw_start) begin
      start_next = 1'b1;
    end
  end

  // start request as a one cycle pulse toward the analog core
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      start_reg <= 1'b0;
    end else if (ce) begin
      start_reg <= start_next;
    end
  end

  assign start_conversion = start_reg;


  // result pair and its freeze

  freeze_state_t pair_reg;
  freeze_state_t pair_next;
  logic [RESULT_W-1:0] result_reg;
  logic [RESULT_W-1:0] result_next;
  logic low_read_pending;
  logic load_block;

  // a low byte read in flight also blocks loading, so the read data and the frozen pair agree
  assign low_read_pending = psel && !pwrite && hit_low;

  // freeze state: low byte read closes the pair, high byte read opens it again
  always_comb begin
    pair_next = pair_reg;
    unique case (pair_reg)
      PAIR_OPEN: begin
        if (rd_take && hit_low) begin
          pair_next = PAIR_FROZEN;
        end
      end
      PAIR_FROZEN: begin
        if (rd_take && hit_high) begin
          pair_next = PAIR_OPEN;
        end
      end
      default: begin
        pair_next = PAIR_OPEN;
      end
    endcase
  end

  assign load_block = (pair_reg == PAIR_FROZEN) || low_read_pending;

  // result store; a result that finishes while frozen is dropped
  always_comb begin
    result_next = result_reg;
    if (conv_done && !load_block) begin
      result_next = conversion_result;
    end
  end

  // freeze state and stored result
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pair_reg <= PAIR_OPEN;
      result_reg <= RESULT_RESET;
    end else if (ce) begin
      pair_reg <= pair_next;
      result_reg <= result_next;
    end
  end


  // read data

  logic [7:0] low_view;
  logic [7:0] high_view;
  logic [7:0] rd_byte;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;

  // adjusted views of the stored result; unused bits read zero
  always_comb begin
    if (left_adjust_reg) begin
      high_view = result_reg[9:2];
      low_view = {result_reg[1:0], 6'h00};
    end else begin
      high_view = {6'h00, result_reg[9:8]};
      low_view = result_reg[7:0];
    end
  end

  // read multiplexer; the start bit reads back zero
  always_comb begin
    rd_byte = 8'h00;
    if (hit_low) begin
      rd_byte = low_view;
    end else if (hit_high) begin
      rd_byte = high_view;
    end else if (hit_ctrl_a) begin
      rd_byte[CTRL_A_ENABLE_BIT] = enable_reg;
      rd_byte[CTRL_A_AUTO_BIT] = auto_reg;
    end else if (hit_ctrl_b) begin
      rd_byte[CTRL_B_SOURCE_LSB +: SOURCE_W] = source_reg;
    end else if (hit_mux) begin
      rd_byte[MUX_LEFT_ADJUST_BIT] = left_adjust_reg;
      rd_byte[MUX_CHANNEL_LSB +: CHANNEL_W] = channel_reg;
    end else if (hit_disable) begin
      rd_byte[DISABLE_LSB +: PIN_W] = disable_reg;
    end
  end

  // read data is captured in the setup phase and held through the access phase
  always_comb begin
    prdata_next = prdata_reg;
    if (setup_phase && !pwrite) begin
      prdata_next = {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata_reg <= PRDATA_RESET;
    end else if (ce) begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;


  // digital pin inputs

  logic [PIN_W-1:0] pin_reg;
  logic [PIN_W-1:0] pin_next;

  // a disabled buffer reads zero, so a floating analog level never reaches the port logic
  always_comb begin
    pin_next = pin_raw & ~disable_reg;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_reg <= PIN_RESET;
    end else if (ce) begin
      pin_reg <= pin_next;
    end
  end

  assign pin_value = pin_reg;

endmodule // adc_trigger_result_regs
`default_nettype wire

// ---- tb/adc_trigger_result_regs_sva.sv ----
// checker: bus, result view, trigger and pin mask assertions for the converter register block
`timescale 1ns/1ps
`default_nettype none
module adc_trigger_result_regs_sva
  import adc_regs_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pslverr,
  input wire logic [FLAG_W-1:0] trigger_flags,
  input wire logic [PIN_W-1:0] pin_raw,
  input wire logic [PIN_W-1:0] pin_value,
  input wire logic [PIN_W-1:0] buffer_disable,
  input wire logic start_conversion,
  input wire logic converter_enable
);
  logic [IDX_W-1:0] idx;
  logic wr;
  logic rd;
  logic mapped;
  logic adj_q;
  logic auto_q;
  logic [SOURCE_W-1:0] src_q;
  // decoded access phase, so each property stays short
  assign idx = paddr[11:2];
  assign wr = psel & penable & pwrite & pstrb[0] & ce;
  assign rd = psel & penable & !pwrite;
  assign mapped = idx inside {IDX_RESULT_LOW, IDX_RESULT_HIGH, IDX_CONTROL_A, IDX_CONTROL_B,
    IDX_MUX_SELECT, IDX_INPUT_DISABLE};
  // shadow of control fields that have no port of their own
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      adj_q <= 1'b0;
      auto_q <= 1'b0;
      src_q <= SOURCE_RESET;
    end else if (wr) begin
      if (idx == IDX_MUX_SELECT) adj_q <= pwdata[MUX_LEFT_ADJUST_BIT];
      if (idx == IDX_CONTROL_A) auto_q <= pwdata[CTRL_A_AUTO_BIT];
      if (idx == IDX_CONTROL_B) src_q <= pwdata[SOURCE_W-1:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  AST_PIN_VALUE: assert property (
    ce |=> pin_value == $past(pin_raw & ~buffer_disable)) else $error("pin value not masked");
  AST_DISABLE_WRITE: assert property (
    wr && idx == IDX_INPUT_DISABLE |=> ##1 buffer_disable == $past(pwdata[5:0], 2))
    else $error("buffer disable not taken from write");
  AST_ENABLE_WRITE: assert property (
    wr && idx == IDX_CONTROL_A |=> ##1 converter_enable == $past(pwdata[7], 2))
    else $error("converter enable not taken from write");
  AST_UPPER_ZERO: assert property (
    rd |-> prdata[31:8] == 24'h00_0000) else $error("read data upper bits set");
  AST_LEFT_LOW: assert property (
    rd && adj_q && idx == IDX_RESULT_LOW |-> prdata[5:0] == 6'h00)
    else $error("left adjusted low byte has low bits set");
  AST_RIGHT_HIGH: assert property (
    rd && !adj_q && idx == IDX_RESULT_HIGH |-> prdata[7:2] == 6'h00)
    else $error("right adjusted high byte has upper bits set");
  AST_UNMAPPED: assert property (
    psel && penable && !mapped |-> pslverr && (pwrite || prdata == 32'h0000_0000))
    else $error("unmapped access not refused");
  AST_ERR_ONLY_ACCESS: assert property (
    pslverr |-> psel && penable) else $error("error outside access phase");
  AST_TRIGGER: assert property (
    ce && $past(ce) && converter_enable && auto_q && $stable(src_q) && trigger_flags[src_q]
    && !$past(trigger_flags[src_q]) |=> start_conversion) else $error("edge gave no start");
  AST_FREE_SWITCH: assert property (
    ce && $changed(src_q) && src_q == 3'h0 |=> !start_conversion)
    else $error("switch to free running started a conversion");
endmodule // adc_trigger_result_regs_sva
bind adc_trigger_result_regs adc_trigger_result_regs_sva chk_i (.mclk(mclk), .nrst(nrst),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr), .trigger_flags(trigger_flags),
  .pin_raw(pin_raw), .pin_value(pin_value), .buffer_disable(buffer_disable),
  .start_conversion(start_conversion), .converter_enable(converter_enable));
`default_nettype wire

// ---- tb/test_adc_trigger_result_regs.sv ----
// testbench: register bus, result pair, auto trigger and pin disable tests of the converter block
`timescale 1ns/1ps
`default_nettype none
module test_adc_trigger_result_regs;
  import adc_regs_pkg::*;
  logic mclk, nrst, ce, psel, penable, pwrite, pready, pslverr, conv_done, err_v;
  logic start_conversion, converter_enable;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd_v;
  logic [3:0] pstrb;
  logic [RESULT_W-1:0] conversion_result;
  logic [FLAG_W-1:0] trigger_flags;
  logic [PIN_W-1:0] pin_raw, pin_value, buffer_disable;
  logic [CHANNEL_W-1:0] channel_select_bits;
  int err_total, n_tests, start_cnt, s;
  // byte addresses: low, high, control a, control b, mux, input disable
  localparam logic [11:0] RA [6] = '{12'h1e0, 12'h1e4, 12'h1e8, 12'h1ec, 12'h1f0, 12'h1f8};

  adc_trigger_result_regs dut (.mclk(mclk), .nrst(nrst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
    .conversion_result(conversion_result), .trigger_flags(trigger_flags), .pin_raw(pin_raw),
    .pin_value(pin_value), .buffer_disable(buffer_disable),
    .start_conversion(start_conversion), .converter_enable(converter_enable),
    .channel_select_bits(channel_select_bits));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // start pulses are counted here so a missing or doubled pulse shows as a wrong count
  always @(posedge mclk) if (start_conversion === 1'b1) start_cnt++;

  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen high at a rising edge
  task apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int guard;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    guard = 0;
    do begin
      @(posedge mclk);
      guard++;
    end while (pready !== 1'b1 && guard < 50);
    if (pready !== 1'b1) err_total++;
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task conv(input logic [9:0] v);
    @(posedge mclk);
    conv_done <= 1'b1;
    conversion_result <= v;
    @(posedge mclk);
    conv_done <= 1'b0;
  endtask
  // settle on source s0 with flags f0, then apply flags f1 and source s1, count starts
  task tcase(input logic [31:0] ca, input logic [2:0] s0, input logic [7:0] f0,
    input logic [2:0] s1, input logic [7:0] f1, input int exp_n);
    apb_xfer(1'b1, RA[2], ca);
    apb_xfer(1'b1, RA[3], {29'h0, s0});
    trigger_flags <= f0;
    repeat (3) @(negedge mclk);
    start_cnt = 0;
    @(posedge mclk);
    trigger_flags <= f1;
    apb_xfer(1'b1, RA[3], {29'h0, s1});
    repeat (4) @(negedge mclk);
    chk(32'(start_cnt), 32'(exp_n));
  endtask

  initial begin
    {nrst, psel, penable, pwrite, conv_done} = 5'h00;
    ce = 1'b1;
    pstrb = 4'hf;
    paddr = '0;
    pwdata = '0;
    conversion_result = '0;
    trigger_flags = '0;
    pin_raw = '0;
    {err_total, n_tests, start_cnt} = {32'h0, 32'h0, 32'h0};
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    for (s = 0; s < 6; s++) begin
      apb_xfer(1'b0, RA[s], 32'h0);
      chk(rd_v, 32'h0000_0000);
    end
    apb_xfer(1'b0, 12'h1f4, 32'h0);
    chk({31'h0, err_v}, 32'h0000_0001);
    $display("test reset done");
    conv(10'h2a5);
    apb_xfer(1'b0, RA[0], 32'h0);
    chk(rd_v, 32'h0000_00a5);
    apb_xfer(1'b0, RA[1], 32'h0);
    chk(rd_v, 32'h0000_0002);
    apb_xfer(1'b1, RA[4], 32'h0000_0020);
    apb_xfer(1'b0, RA[1], 32'h0);
    chk(rd_v, 32'h0000_00a9);
    apb_xfer(1'b0, RA[0], 32'h0);
    chk(rd_v, 32'h0000_0040);
    conv(10'h155);
    apb_xfer(1'b0, RA[1], 32'h0);
    chk(rd_v, 32'h0000_00a9);
    conv(10'h155);
    apb_xfer(1'b0, RA[1], 32'h0);
    chk(rd_v, 32'h0000_0055);
    conv(10'h3ff);
    apb_xfer(1'b0, RA[1], 32'h0);
    chk(rd_v, 32'h0000_00ff);
    // a result finishing while the clock enable is low must not be stored
    @(posedge mclk);
    ce <= 1'b0;
    conv(10'h000);
    ce <= 1'b1;
    apb_xfer(1'b0, RA[1], 32'h0);
    chk(rd_v, 32'h0000_00ff);
    $display("test result done");
    for (s = 0; s < 8; s++) tcase(32'h0000_00a0, 3'(s), 8'h00, 3'(s), 8'h01 << s, 1);
    tcase(32'h0000_00a0, 3'h1, 8'h08, 3'h3, 8'h08, 1);
    tcase(32'h0000_00a0, 3'h1, 8'h01, 3'h0, 8'h01, 0);
    tcase(32'h0000_0080, 3'h2, 8'h00, 3'h2, 8'h04, 0);
    apb_xfer(1'b0, RA[3], 32'h0);
    chk(rd_v, 32'h0000_0002);
    $display("test trigger done");
    pin_raw <= 6'h3f;
    apb_xfer(1'b1, RA[5], 32'h0000_0015);
    apb_xfer(1'b1, RA[4], 32'h0000_000b);
    repeat (3) @(negedge mclk);
    chk({26'h0, buffer_disable}, 32'h0000_0015);
    chk({26'h0, pin_value}, 32'h0000_002a);
    chk({28'h0, channel_select_bits}, 32'h0000_000b);
    $display("test pins done");
    end_sim;
  end
  // a hung handshake ends the run through the same closing task
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    end_sim;
  end
endmodule // test_adc_trigger_result_regs
`default_nettype wire
